// ---- pmc_pkg.sv ----
// Power mode control package: register layout, states, timing constants.
// Assumes an 8-bit register port and a 50 MHz oscillator clock.
package pmc_pkg;
  localparam logic [7:0] PMC_PCR_ADDR = 8'h87;
  localparam int PMC_IDL_BIT = 0;
  localparam int PMC_PD_BIT = 1;
  localparam int PMC_GF0_BIT = 2;
  localparam int PMC_GF1_BIT = 3;
  localparam logic [7:0] PMC_PCR_RESET = 8'h00;
  localparam logic [7:0] PMC_UNMAPPED = 8'h00;
  localparam int PMC_CLK_NS = 20;
  localparam int PMC_OSC_SETTLE_NS = 200;
  localparam int PMC_OSC_SETTLE_CYC =
    (PMC_OSC_SETTLE_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
  localparam int PMC_RESUME_CYC = 4;
  localparam int PMC_CNT_W = 8;
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_IDLE = 3'b001,
    PMC_PDWN = 3'b010,
    PMC_WAKE = 3'b011,
    PMC_RELEASE = 3'b100
  } pmc_state_t;
endpackage

// ---- pmc_power_mode_control.sv ----
// Power mode controller: idle and power-down entry, wake-up and pin states.
// Assumes the CPU raises instr_done at the end of each instruction.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
// Operation
// - Setting the idle bit enters idle when that instruction completes.
// - Idle gates the CPU clock; peripherals keep running; state preserved.
// - Idle and power-down set together enter power-down only.
// - Enabled interrupt in idle clears idle bit and restores CPU clock.
// - Reset pin clears idle bit asynchronously.
// - Internal RAM blocked while execution resumes before reset takes over.
// - Setting power-down bit enters power-down when that instruction completes.
// - Power-down stops oscillator and all clocks; state preserved.
// - External interrupt wakes power-down; execution resumes once pin released.
// - Interrupt wake-up leaves registers and RAM unchanged.
// - Reset pin clears power-down bit asynchronously, restarts oscillator.
// - Reset wake-up reinitialises registers but keeps RAM.
// - Keyboard interrupt wakes power-down like external interrupt lines.
// - Pin conditions per mode for port 0, ports and bus strobes.
// - Power-down bit cleared by hardware on interrupt or reset wake.
module pmc_power_mode_control (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rst_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic ext_irq_line_zero,
  input wire logic ext_irq_line_one,
  input wire logic ext_irq_en_zero,
  input wire logic ext_irq_en_one,
  input wire logic kbd_irq,
  input wire logic kbd_irq_en,
  input wire logic ext_code,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic ram_block,
  output logic sfr_reinit,
  output logic port0_oe_n,
  output logic ports_force_high,
  output logic ale_level,
  output logic program_store_strobe
);
  import pmc_pkg::*;

  logic rst_s1_q, rst_s2_q;
  logic rpin_s1_q, rpin_s2_q;
  logic [2:0] wk_s1_q, wk_s2_q;
  logic idle_request_bit_q, powerdown_request_bit_q;
  logic general_flag_zero_q, general_flag_one_q;
  pmc_state_t state_q, state_d;
  logic [PMC_CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] rdata_q;
  logic rst_n;
  logic pin_reset_n;
  logic pcr_wr, pcr_rd;
  logic wake_lines, pd_wake;
  logic resume_q;

  // Internal reset: async assert, release on the first clock edge (both stages load 1 together)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end
  end
  assign rst_n = rst_s2_q;

  // Wake pins synchronised before use; reset pin synchronised for the sequencer and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rpin_s1_q <= 1'b0;
      rpin_s2_q <= 1'b0;
      wk_s1_q <= 3'b000;
      wk_s2_q <= 3'b000;
    end else begin
      rpin_s1_q <= rst_pin;
      rpin_s2_q <= rpin_s1_q;
      wk_s1_q <= {kbd_irq, ~ext_irq_line_one, ~ext_irq_line_zero};
      wk_s2_q <= wk_s1_q;
    end
  end

  // Reset pin acts directly on the mode bits
  assign pin_reset_n = rst_n & ~rst_pin;

  // Register port decode and wake source combine
  assign pcr_wr = wr && (addr == PMC_PCR_ADDR);
  assign pcr_rd = rd && (addr == PMC_PCR_ADDR);
  assign wake_lines = (wk_s2_q[0] & ext_irq_en_zero) | (wk_s2_q[1] & ext_irq_en_one)
                    | (wk_s2_q[2] & kbd_irq_en);
  assign pd_wake = (state_q == PMC_PDWN) && wake_lines;

  always_ff @(posedge clk or negedge pin_reset_n) begin
    if (!pin_reset_n) begin
      idle_request_bit_q <= 1'b0;
      powerdown_request_bit_q <= 1'b0;
    end else begin
      if (pd_wake) begin
        powerdown_request_bit_q <= 1'b0;
        idle_request_bit_q <= 1'b0;
      end else if (state_q == PMC_IDLE && irq_pending) begin
        idle_request_bit_q <= 1'b0;
      end else if (pcr_wr) begin
        idle_request_bit_q <= wdata[PMC_IDL_BIT];
        powerdown_request_bit_q <= wdata[PMC_PD_BIT];
      end
    end
  end

  // Flags only change on software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_flag_zero_q <= PMC_PCR_RESET[PMC_GF0_BIT];
      general_flag_one_q <= PMC_PCR_RESET[PMC_GF1_BIT];
    end else if (pcr_wr) begin
      general_flag_zero_q <= wdata[PMC_GF0_BIT];
      general_flag_one_q <= wdata[PMC_GF1_BIT];
    end
  end

  // Mode sequencer: run, idle, power-down, oscillator settle, pin release
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      PMC_RUN: begin
        if (instr_done && powerdown_request_bit_q) begin
          state_d = PMC_PDWN;
        end else if (instr_done && idle_request_bit_q) begin
          state_d = PMC_IDLE;
        end
      end
      PMC_IDLE: begin
        if (!idle_request_bit_q) begin
          state_d = PMC_RUN;
        end
      end
      PMC_PDWN: begin
        if (pd_wake) begin
          state_d = PMC_WAKE;
          cnt_d = PMC_CNT_W'(PMC_OSC_SETTLE_CYC);
        end else if (!powerdown_request_bit_q) begin
          state_d = PMC_RUN;
        end
      end
      PMC_WAKE: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          state_d = PMC_RELEASE;
        end
      end
      PMC_RELEASE: begin
        if (!wake_lines) begin
          state_d = PMC_RUN;
        end
      end
      default: state_d = PMC_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PMC_RUN;
      cnt_q <= '0;
      resume_q <= 1'b0;
    end else begin
      // Reset pin in low power: hold RAM until internal reset lands
      state_q <= rpin_s2_q ? PMC_RUN : state_d;
      cnt_q <= cnt_d;
      resume_q <= rpin_s2_q && (state_q != PMC_RUN || resume_q);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= PMC_UNMAPPED;
    end else if (pcr_rd) begin
      rdata_q <= {4'h0, general_flag_one_q, general_flag_zero_q,
                  powerdown_request_bit_q, idle_request_bit_q};
    end else begin
      rdata_q <= PMC_UNMAPPED;
    end
  end
  assign rdata = rdata_q;

  // Clock gates and pin conditions follow the registered state
  assign cpu_clk_en = (state_q == PMC_RUN);
  assign periph_clk_en = (state_q != PMC_PDWN) && (state_q != PMC_WAKE);
  assign osc_en = (state_q != PMC_PDWN);
  assign ram_block = resume_q | rpin_s2_q;
  assign sfr_reinit = ~rst_n | rpin_s2_q;
  // Port 0 floats in reset and in low power with external code
  assign port0_oe_n = ~rst_n | rpin_s2_q | (ext_code && state_q != PMC_RUN);
  assign ports_force_high = ~rst_n | rpin_s2_q;
  assign ale_level = ~(state_q == PMC_PDWN || state_q == PMC_WAKE);
  assign program_store_strobe = ale_level;


  // Mode bits still clear when the reset pin falls
  rst_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rst_pin) |-> !idle_request_bit_q && !powerdown_request_bit_q)
    else $error("reset pin left a mode bit set");

  // Mode bits held clear while the reset pin is high
  rst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_pin |-> !idle_request_bit_q && !powerdown_request_bit_q)
    else $error("mode bit set under reset pin");

  // Power-down wins over idle
  pd_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_RUN && instr_done && powerdown_request_bit_q && !rpin_s2_q
    |=> state_q == PMC_PDWN)
    else $error("power-down not taken first");

  // Idle entry at instruction end
  idle_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_RUN && instr_done && idle_request_bit_q && !powerdown_request_bit_q
    && !rpin_s2_q |=> !cpu_clk_en && periph_clk_en)
    else $error("idle entry wrong");

  // Idle keeps peripherals clocked
  idle_clk_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_IDLE |-> !cpu_clk_en && periph_clk_en && osc_en)
    else $error("idle clock gates wrong");

  // Interrupt in idle clears the bit, then the CPU clock returns
  idle_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_IDLE && irq_pending && !pcr_wr && !rpin_s2_q
    |=> !idle_request_bit_q ##1 cpu_clk_en)
    else $error("idle exit wrong");

  // Power-down entry at instruction end
  pd_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_RUN && instr_done && powerdown_request_bit_q && !rpin_s2_q
    |=> !osc_en && !cpu_clk_en)
    else $error("power-down entry wrong");

  // Everything frozen in power-down
  pd_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_PDWN |-> !osc_en && !periph_clk_en && !program_store_strobe)
    else $error("clocks running in power-down");

  // Wake clears the power-down bit and starts the settle count
  pd_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    pd_wake && !rpin_s2_q |=> !powerdown_request_bit_q && state_q == PMC_WAKE)
    else $error("wake did not clear power-down bit");

  // Settle count loaded with the full oscillator settle time
  settle_ld_a: assert property (@(posedge clk) disable iff (!rst_n)
    pd_wake && !rpin_s2_q |=> cnt_q == PMC_CNT_W'(PMC_OSC_SETTLE_CYC))
    else $error("settle count not loaded");

  // Oscillator runs while settling, CPU still stopped
  settle_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_WAKE |-> osc_en && !cpu_clk_en && !periph_clk_en)
    else $error("settle clock gates wrong");

  // Settle end moves on to pin release
  settle_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_WAKE && cnt_q == '0 && !rpin_s2_q |=> state_q == PMC_RELEASE)
    else $error("settle end missed");

  // No resume while the wake pin is still held
  hold_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_RELEASE && wake_lines && !rpin_s2_q |=> !cpu_clk_en)
    else $error("resumed before wake pin released");

  // Resume once the wake pin is released
  rel_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PMC_RELEASE && !wake_lines && !rpin_s2_q |=> cpu_clk_en)
    else $error("no resume after wake pin release");

  // Interrupt wake leaves the registers alone
  wake_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PMC_WAKE || state_q == PMC_RELEASE) && !rpin_s2_q |-> !sfr_reinit)
    else $error("registers reset on interrupt wake");

  // Reset pin blocks RAM and reinitialises registers, back to run
  rpin_act_a: assert property (@(posedge clk) disable iff (!rst_n)
    rpin_s2_q |-> ram_block && sfr_reinit ##1 state_q == PMC_RUN)
    else $error("reset pin effect wrong");

  // Flags change only on a write
  flag_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pcr_wr |=> $stable(general_flag_zero_q) && $stable(general_flag_one_q))
    else $error("general flag changed without write");

  // Idle pin conditions with external code
  p0_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_code && state_q == PMC_IDLE |-> port0_oe_n && ale_level)
    else $error("idle pin conditions wrong");

  // Port 0 driven in low power with internal code
  p0_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_code && state_q != PMC_RUN && !rpin_s2_q |-> !port0_oe_n && !ports_force_high)
    else $error("port 0 not driven in low power");
endmodule

// ---- pmc_cpu_model.sv ----
// CPU core and wake sources standing around the power mode controller.
// Assumes the testbench picks the wake source and raises wake_go.
`timescale 1ns/1ps
module pmc_cpu_model (
  input wire logic clk,
  input wire logic cpu_clk_en,
  input wire logic osc_en,
  input wire logic [1:0] wake_sel,
  input wire logic wake_go,
  output logic instr_done,
  output logic irq_pending,
  output logic ext_irq_line_zero,
  output logic ext_irq_line_one,
  output logic kbd_irq
);
  logic [1:0] phase_q = 2'h0;
  logic [4:0] held_q = 5'h00;
  logic hold;
  // Instruction ends every fourth cycle while the CPU clock runs
  always_ff @(posedge clk) begin
    phase_q <= cpu_clk_en ? phase_q + 2'h1 : 2'h0;
    if (!wake_go) begin
      held_q <= 5'h00;
    end else if (osc_en && held_q != 5'h1f) begin
      held_q <= held_q + 5'h01;
    end
  end
  assign instr_done = cpu_clk_en && (phase_q == 2'h3);
  // Level wake held until the oscillator has run 16 cycles
  assign hold = wake_go && (held_q < 5'h10);
  assign ext_irq_line_zero = !(hold && wake_sel == 2'h0);
  assign ext_irq_line_one = !(hold && wake_sel == 2'h1);
  assign kbd_irq = hold && wake_sel == 2'h2;
  assign irq_pending = hold && wake_sel == 2'h3;
endmodule

// ---- testbench.sv ----
// Self-checking bench for the power mode controller.
// Assumes pmc_cpu_model plays the CPU core and the wake pins.
`timescale 1ns/1ps
module testbench;
  import pmc_pkg::*;
  logic clk = 1'b0;
  logic nrst, rst_pin, wr, rd, rd_d, ext_code, wake_go, en;
  logic [7:0] addr, wdata, rdata, gf;
  logic [1:0] wake_sel;
  logic instr_done, irq_pending, ext0, ext1, kbd, cpu_clk_en, periph_clk_en, osc_en;
  logic ram_block, sfr_reinit, port0_oe_n, ports_force_high, ale_level, program_store_strobe;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  integer seed = 32'h0cd6;
  always #10 clk = ~clk;
  pmc_power_mode_control dut (.clk(clk), .nrst(nrst), .rst_pin(rst_pin), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .instr_done(instr_done),
    .irq_pending(irq_pending), .ext_irq_line_zero(ext0), .ext_irq_line_one(ext1),
    .ext_irq_en_zero(en), .ext_irq_en_one(en), .kbd_irq(kbd), .kbd_irq_en(en),
    .ext_code(ext_code), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_en(osc_en), .ram_block(ram_block), .sfr_reinit(sfr_reinit),
    .port0_oe_n(port0_oe_n), .ports_force_high(ports_force_high),
    .ale_level(ale_level), .program_store_strobe(program_store_strobe));
  pmc_cpu_model cpu (.clk(clk), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
    .wake_sel(wake_sel), .wake_go(wake_go), .instr_done(instr_done),
    .irq_pending(irq_pending), .ext_irq_line_zero(ext0), .ext_irq_line_one(ext1),
    .kbd_irq(kbd));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checked=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    access(1'b0, a, 8'h00);
  endtask
  task automatic wait_sig(input int k, input logic lvl);
    int n = 0;
    while ((k == 0 ? cpu_clk_en : osc_en) !== lvl && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // Read data is due in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d === 1'b1) check(rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    {nrst, rst_pin, wr, rd, rd_d, ext_code, wake_go, addr, wdata, wake_sel} = '0;
    en = 1'b1;
    repeat (10) @(posedge clk);
    check(port0_oe_n, 1'b1);
    check(ports_force_high, 1'b1);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(PMC_PCR_ADDR, PMC_PCR_RESET);
    rd_reg(8'h42, PMC_UNMAPPED);
    gf = 8'($random(seed)) & 8'h0c;
    access(1'b1, PMC_PCR_ADDR, gf | 8'h01);
    wait_sig(0, 1'b0);
    check(periph_clk_en, 1'b1);
    check(ale_level, 1'b1);
    wake_sel <= 2'h3;
    wake_go <= 1'b1;
    wait_sig(0, 1'b1);
    wake_go <= 1'b0;
    rd_reg(PMC_PCR_ADDR, gf);
    $display("idle test done");
    for (int i = 0; i < 3; i++) begin
      ext_code <= i[0];
      wake_sel <= i[1:0];
      access(1'b1, PMC_PCR_ADDR, gf | (i == 0 ? 8'h03 : 8'h02));
      wait_sig(1, 1'b0);
      check(cpu_clk_en, 1'b0);
      check(program_store_strobe, 1'b0);
      check(port0_oe_n, i[0]);
      wake_go <= 1'b1;
      wait_sig(1, 1'b1);
      if (i != 0) rd_reg(PMC_PCR_ADDR, gf);
      wait_sig(0, 1'b1);
      repeat (6) begin
        @(posedge clk);
        check(cpu_clk_en, 1'b1);
      end
      wake_go <= 1'b0;
      $display("power-down wake test %0d done", i);
    end
    for (int m = 0; m < 2; m++) begin
      access(1'b1, PMC_PCR_ADDR, 8'(8'h01 << m));
      wait_sig(m, 1'b0);
      rst_pin <= 1'b1;
      wait_sig(m, 1'b1);
      repeat (2) @(posedge clk);
      check(sfr_reinit, 1'b1);
      if (m == 0) check(ram_block, 1'b1);
      rst_pin <= 1'b0;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_reg(PMC_PCR_ADDR, PMC_PCR_RESET);
      $display("reset pin test %0d done", m);
    end
    end_of_test();
  end
endmodule
